/* File: pkg/pdirq_regs.vh */
// Purpose: Offsets, field positions and reset values of the interrupt block
// Assumes: 8-bit registers on a byte address bus
// Notes: Status groups for transmit, receive and receive-error come in as
//        vectors from the MAC core.
`ifndef PDIRQ_REGS_VH
`define PDIRQ_REGS_VH

`define PDIRQ_ADDR_W 16
`define PDIRQ_OFS_PM_STAT 16'h1a84
`define PDIRQ_OFS_SOP_STAT 16'h1a85
`define PDIRQ_OFS_TX_EN 16'h1a86
`define PDIRQ_OFS_RX_EN 16'h1a87
`define PDIRQ_OFS_RXERR_EN 16'h1a88
`define PDIRQ_OFS_PM_EN 16'h1a89
`define PDIRQ_OFS_SOP_EN 16'h1a8a

`define PDIRQ_RST_VAL 8'h00
`define PDIRQ_PM_STAT_MASK 8'h01
`define PDIRQ_SOP_MASK 8'h1f
`define PDIRQ_TX_EN_MASK 8'hff
`define PDIRQ_RX_EN_MASK 8'hef
`define PDIRQ_RXERR_EN_MASK 8'h8f
`define PDIRQ_PM_EN_MASK 8'h0d

`define PDIRQ_BIT_ACT_WS_EN 0
`define PDIRQ_BIT_WU_EN 2
`define PDIRQ_BIT_CLK_STOP_EN 3
`define PDIRQ_SOP_W 5

`endif

/* File: rtl/pdirq_top.v */
// Purpose: Interrupt status, enables and clock request logic of the PD MAC
// Assumes: Byte-wide register port, single-cycle write and read strobes
// Notes: Transmit, receive and receive-error status come from the MAC core
`timescale 1ns/1ps
`default_nettype none
`include "pdirq_regs.vh"

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Activity flag sets asynchronously on receive assertion
// - Activity flag never sets while enable clear
// - Activity flag ignores clock stop and wakeup enables
// - Five sticky frame start flags, write one clears
// - Frame start flags set regardless of receive enables
// - Frame start flags drive own separate interrupt
// - Enables gate interrupts only, status still records, except the activity enable, which also blocks the flag
// - Transmit enable mask, eight bits, reset zero
// - Receive enable mask, bit four reserved
// - Receive error mask, bits six to four reserved
// - Power enable bits zero, two, three
// - Clock stop enable requests stop when idle and squelch inactive
// - Idle MAC drops its clock need unless squelch or the wake window holds it
// - Wakeup enable requests clock on activity flag while squelch inactive
// - Squelch active means clock needed regardless
module pdirq_top (
  // Clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // Register port
  input wire [15:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Line and MAC status
  input wire rx_activity_i,
  input wire squelch_active_i,
  input wire mac_idle_i,
  input wire [4:0] frame_start_seen_i,
  input wire [7:0] tx_status_i,
  input wire [7:0] rx_status_i,
  input wire [7:0] rx_err_status_i,
  // Interrupts
  output wire tx_irq_o,
  output wire rx_irq_o,
  output wire rx_err_irq_o,
  output wire pm_irq_o,
  output wire frame_start_irq_o,
  // Clock controller
  output wire clock_needed_o,
  output wire clock_start_req_o,
  output wire clock_stop_req_o
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] frame_start_type_status_ff;
  reg [7:0] transmit_event_enable_ff;
  reg [7:0] receive_event_enable_ff;
  reg [7:0] receive_error_enable_ff;
  reg [7:0] pm_enable_and_clock_control_ff;
  reg [7:0] frame_start_enable_ff;
  reg [7:0] nxt_rdata;
  reg sq1_ff;
  reg sq2_ff;
  reg sq3_ff;
  reg squelch_ff;
  reg waking_ff;
  reg stop_req_ff;
  wire line_activity_wake_flag;
  wire line_activity_wake_enable;
  wire wakeup_clock_request_enable;
  wire clock_stop_request_enable;
  wire pm_clear;

  function sel;
    input [15:0] a;
    input [15:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  function any_enabled;
    input [7:0] stat;
    input [7:0] en;
    begin
      any_enabled = |(stat & en);
    end
  endfunction

  assign line_activity_wake_enable =
    pm_enable_and_clock_control_ff[`PDIRQ_BIT_ACT_WS_EN];
  assign wakeup_clock_request_enable =
    pm_enable_and_clock_control_ff[`PDIRQ_BIT_WU_EN];
  assign clock_stop_request_enable =
    pm_enable_and_clock_control_ff[`PDIRQ_BIT_CLK_STOP_EN];

  // Write one to bit 0 clears the asynchronous catcher
  assign pm_clear = reg_wr_i & sel(reg_addr_i, `PDIRQ_OFS_PM_STAT) &
    reg_wdata_i[0];

  ////////////////////////////////////////////////////////////////////////
  // Activity wake flag
  pdirq_wake_sync u_wake (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .rx_activity_i(rx_activity_i),
    .wake_enable_i(line_activity_wake_enable),
    .clear_i(pm_clear),
    .wake_flag_o(line_activity_wake_flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // Frame start flags; set wins over a same-cycle clear
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      frame_start_type_status_ff <= `PDIRQ_RST_VAL;
    end else begin
      frame_start_type_status_ff <= `PDIRQ_SOP_MASK &
        (({3'h0, frame_start_seen_i}) |
         (frame_start_type_status_ff &
          ~((reg_wr_i && sel(reg_addr_i, `PDIRQ_OFS_SOP_STAT)) ?
            reg_wdata_i : 8'h00)));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable registers, reserved bits masked off on write
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      transmit_event_enable_ff <= `PDIRQ_RST_VAL;
      receive_event_enable_ff <= `PDIRQ_RST_VAL;
      receive_error_enable_ff <= `PDIRQ_RST_VAL;
      pm_enable_and_clock_control_ff <= `PDIRQ_RST_VAL;
      frame_start_enable_ff <= `PDIRQ_RST_VAL;
    end else if (reg_wr_i) begin
      if (sel(reg_addr_i, `PDIRQ_OFS_TX_EN)) begin
        transmit_event_enable_ff <= reg_wdata_i & `PDIRQ_TX_EN_MASK;
      end
      if (sel(reg_addr_i, `PDIRQ_OFS_RX_EN)) begin
        receive_event_enable_ff <= reg_wdata_i & `PDIRQ_RX_EN_MASK;
      end
      if (sel(reg_addr_i, `PDIRQ_OFS_RXERR_EN)) begin
        receive_error_enable_ff <= reg_wdata_i & `PDIRQ_RXERR_EN_MASK;
      end
      if (sel(reg_addr_i, `PDIRQ_OFS_PM_EN)) begin
        pm_enable_and_clock_control_ff <= reg_wdata_i &
          `PDIRQ_PM_EN_MASK;
      end
      if (sel(reg_addr_i, `PDIRQ_OFS_SOP_EN)) begin
        frame_start_enable_ff <= reg_wdata_i & `PDIRQ_SOP_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered; unmapped and reserved read as zero
  always @* begin
    nxt_rdata = 8'h00;
    case (reg_addr_i)
      `PDIRQ_OFS_PM_STAT: nxt_rdata = {7'h00, line_activity_wake_flag};
      `PDIRQ_OFS_SOP_STAT: nxt_rdata = frame_start_type_status_ff;
      `PDIRQ_OFS_TX_EN: nxt_rdata = transmit_event_enable_ff;
      `PDIRQ_OFS_RX_EN: nxt_rdata = receive_event_enable_ff;
      `PDIRQ_OFS_RXERR_EN: nxt_rdata = receive_error_enable_ff;
      `PDIRQ_OFS_PM_EN: nxt_rdata = pm_enable_and_clock_control_ff;
      `PDIRQ_OFS_SOP_EN: nxt_rdata = frame_start_enable_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt outputs; each status group ANDed with its enables
  assign tx_irq_o = any_enabled(tx_status_i,
    transmit_event_enable_ff);
  assign rx_irq_o = any_enabled(rx_status_i,
    receive_event_enable_ff);
  assign rx_err_irq_o = any_enabled(rx_err_status_i,
    receive_error_enable_ff);
  assign pm_irq_o = line_activity_wake_flag &
    line_activity_wake_enable;
  // Own output, not folded into the receive group
  assign frame_start_irq_o = any_enabled(frame_start_type_status_ff,
    frame_start_enable_ff);

  ////////////////////////////////////////////////////////////////////////
  // Clock requests; squelch is a pin, three flops, change once 2nd = 3rd
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sq1_ff <= 1'b0;
      sq2_ff <= 1'b0;
      sq3_ff <= 1'b0;
      squelch_ff <= 1'b0;
      waking_ff <= 1'b0;
      stop_req_ff <= 1'b0;
    end else begin
      sq1_ff <= squelch_active_i;
      sq2_ff <= sq1_ff;
      sq3_ff <= sq2_ff;
      if (sq2_ff == sq3_ff) begin
        squelch_ff <= sq3_ff;
      end
      // Wake window ends when squelch starts or the flag is cleared
      if (squelch_ff || !line_activity_wake_flag) begin
        waking_ff <= 1'b0;
      end else if (wakeup_clock_request_enable) begin
        waking_ff <= 1'b1;
      end
      stop_req_ff <= clock_stop_request_enable & mac_idle_i &
        ~squelch_ff;
    end
  end

  // Start request also raised straight from the synchronised flag, not via waking_ff
  assign clock_start_req_o = wakeup_clock_request_enable &
    line_activity_wake_flag & ~squelch_ff;
  // Need follows squelch regardless of the wakeup enable
  assign clock_needed_o = squelch_ff |
    (~mac_idle_i) | waking_ff;
  assign clock_stop_req_o = stop_req_ff;

endmodule // pdirq_top
`default_nettype wire

/* File: rtl/pdirq_wake_sync.v */
// Purpose: Catches line activity without a clock and hands it to the core
// Assumes: Activity input is a raw pin level, enable from the core clock
// Notes: Flag capture is asynchronous by design; output is synchronised
`timescale 1ns/1ps
`default_nettype none
module pdirq_wake_sync (
  // Clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // Capture
  input wire rx_activity_i,
  input wire wake_enable_i,
  input wire clear_i,
  // Result
  output wire wake_flag_o
);

  reg catch_ff;
  reg sync1_ff;
  reg sync2_ff;
  wire catch_clr_n;

  // Enable clear holds the catcher in reset so it can never set
  assign catch_clr_n = nrst_i & wake_enable_i & ~clear_i;

  // Set by the activity edge itself, no clock needed
  always @(posedge rx_activity_i or negedge catch_clr_n) begin
    if (!catch_clr_n) begin
      catch_ff <= 1'b0;
    end else begin
      catch_ff <= 1'b1;
    end
  end

  // Two stages before the core logic reads it
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= catch_ff;
      sync2_ff <= sync1_ff;
    end
  end

  assign wake_flag_o = sync2_ff;

endmodule // pdirq_wake_sync
`default_nettype wire

/* File: tb/pd_mac_irq_and_clock_wake_test.sv */
// Purpose: Register and port tests of pdirq_top
// Assumes: Inputs change on the falling edge
// Notes: Read data is checked one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module pd_mac_irq_and_clock_wake_test;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic rx_activity_i = 1'b0, squelch_active_i = 1'b0, mac_idle_i = 1'b1;
  logic [15:0] reg_addr_i = 16'h0000;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
  logic [4:0] frame_start_seen_i = 5'h00;
  logic [7:0] tx_status_i = 8'h00, rx_status_i = 8'h00;
  logic [7:0] rx_err_status_i = 8'h00;
  logic tx_irq_o, rx_irq_o, rx_err_irq_o, pm_irq_o, frame_start_irq_o;
  logic clock_needed_o, clock_start_req_o, clock_stop_req_o;
  logic [7:0] msk [6] = '{8'h00, 8'h00, 8'hff, 8'hef, 8'h8f, 8'h0d};
  int n_fail = 0, checked = 0, i;
  pdirq_top DUT (.*);
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_wr_i = 1'b1; reg_addr_i = a; reg_wdata_i = d;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge core_clk_i);
    reg_rd_i = 1'b1; reg_addr_i = a;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_fail++;
    complete_run;
  end
  initial begin
    idle(3);
    nrst_i = 1'b1;
    for (i = 0; i < 8; i++) rd(16'h1a84 + 16'(i), 8'h00);
    chk({7'h0, clock_needed_o}, 8'h00);
    mac_idle_i = 1'b0;
    idle(1);
    chk({7'h0, clock_needed_o}, 8'h01);
    mac_idle_i = 1'b1;
    for (i = 0; i < 6; i++) begin
      wr(16'h1a84 + 16'(i), 8'hff);
      rd(16'h1a84 + 16'(i), msk[i]);
    end
    chk({7'h0, clock_stop_req_o}, 8'h01);
    $display("test registers done");
    tx_status_i = 8'h01; rx_status_i = 8'h10; rx_err_status_i = 8'h70;
    idle(1);
    chk({5'h0, tx_irq_o, rx_irq_o, rx_err_irq_o}, 8'h04);
    rx_status_i = 8'h01; rx_err_status_i = 8'h80;
    idle(1);
    chk({5'h0, tx_irq_o, rx_irq_o, rx_err_irq_o}, 8'h07);
    wr(16'h1a86, 8'h00);
    chk({7'h0, tx_irq_o}, 8'h00);
    rx_status_i = 8'h00;
    $display("test masks done");
    wr(16'h1a8a, 8'h1f);
    for (i = 0; i < 5; i++) begin
      frame_start_seen_i = 5'h01 << i;
      idle(1);
      frame_start_seen_i = 5'h00;
      rd(16'h1a85, 8'h01 << i);
      chk({6'h0, frame_start_irq_o, rx_irq_o}, 8'h02);
      wr(16'h1a85, 8'h01 << i);
      rd(16'h1a85, 8'h00);
    end
    $display("test frame start done");
    wr(16'h1a89, 8'h00);
    rx_activity_i = 1'b1;
    idle(3);
    rd(16'h1a84, 8'h00);
    rx_activity_i = 1'b0;
    wr(16'h1a89, 8'h01);
    rx_activity_i = 1'b1;
    idle(3);
    rd(16'h1a84, 8'h01);
    chk({6'h0, pm_irq_o, clock_start_req_o}, 8'h02);
    rx_activity_i = 1'b0;
    wr(16'h1a84, 8'h01);
    idle(3);
    rd(16'h1a84, 8'h00);
    $display("test wake done");
    wr(16'h1a89, 8'h05);
    rx_activity_i = 1'b1;
    idle(3);
    chk({7'h0, clock_start_req_o}, 8'h01);
    squelch_active_i = 1'b1;
    idle(6);
    chk({6'h0, clock_start_req_o, clock_needed_o}, 8'h01);
    wr(16'h1a89, 8'h08);
    chk({7'h0, clock_stop_req_o}, 8'h00);
    squelch_active_i = 1'b0;
    rx_activity_i = 1'b0;
    idle(6);
    chk({7'h0, clock_stop_req_o}, 8'h01);
    wr(16'h1a89, 8'h00);
    idle(1);
    chk({7'h0, clock_stop_req_o}, 8'h00);
    $display("test clock requests done");
    complete_run;
  end
endmodule // pd_mac_irq_and_clock_wake_test
bind pdirq_top pdirq_checker u_chk (.core_clk_i, .nrst_i, .rx_activity_i,
  .squelch_active_i, .mac_idle_i, .frame_start_seen_i, .tx_status_i,
  .rx_status_i, .rx_err_status_i, .tx_irq_o, .rx_irq_o, .rx_err_irq_o,
  .pm_irq_o, .frame_start_irq_o, .clock_needed_o, .clock_start_req_o,
  .clock_stop_req_o);
`default_nettype wire

/* File: tb/pdirq_checker.sv */
// Purpose: Port assertions for pdirq_top
// Assumes: One clock, sync active-low reset
// Notes: Sees only the top ports
`timescale 1ns/1ps
`default_nettype none
module pdirq_checker (
  // Clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // Inputs seen
  input wire rx_activity_i,
  input wire squelch_active_i,
  input wire mac_idle_i,
  input wire [4:0] frame_start_seen_i,
  input wire [7:0] tx_status_i,
  input wire [7:0] rx_status_i,
  input wire [7:0] rx_err_status_i,
  // Outputs seen
  input wire tx_irq_o,
  input wire rx_irq_o,
  input wire rx_err_irq_o,
  input wire pm_irq_o,
  input wire frame_start_irq_o,
  input wire clock_needed_o,
  input wire clock_start_req_o,
  input wire clock_stop_req_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_tx; tx_irq_o |-> |tx_status_i; endproperty
  a_tx: assert property (p_tx) else $error("tx irq without cause");
  property p_rx; rx_irq_o |-> |(rx_status_i & 8'hef); endproperty
  a_rx: assert property (p_rx) else $error("rx irq bad cause");
  property p_err; rx_err_irq_o |-> |(rx_err_status_i & 8'h8f); endproperty
  a_err: assert property (p_err) else $error("err irq bad cause");
  property p_need; squelch_active_i [*5] |-> clock_needed_o; endproperty
  a_need: assert property (p_need) else $error("clock need missing");
  property p_start; squelch_active_i [*5] |-> !clock_start_req_o; endproperty
  a_start: assert property (p_start) else $error("start req late");
  property p_stop; clock_stop_req_o |-> $past(mac_idle_i); endproperty
  a_stop: assert property (p_stop) else $error("stop req not idle");
  property p_pm; $rose(pm_irq_o) |-> $past(rx_activity_i); endproperty
  a_pm: assert property (p_pm) else $error("wake irq no activity");
  property p_sop; $rose(frame_start_irq_o) |-> $past(|frame_start_seen_i);
  endproperty
  a_sop: assert property (p_sop) else $error("frame irq no pulse");
  c_pm: cover property (pm_irq_o);
  c_sop: cover property (frame_start_irq_o);
  c_stop: cover property (clock_stop_req_o);
  c_start: cover property (clock_start_req_o);
endmodule // pdirq_checker
`default_nettype wire
